// ---- hw/edpc_pkg.sv ----
// constants, register layout and states of the energy-sense power control block
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package edpc_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] CTRL_IDX = 8'h1D;
	localparam logic [7:0] IRQ_STAT_IDX = 8'h1E;
	localparam logic [7:0] IRQ_MASK_IDX = 8'h1F;
	localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
	localparam logic [11:0] IRQ_STAT_ADDR = {2'h0, IRQ_STAT_IDX, 2'h0};
	localparam logic [11:0] IRQ_MASK_ADDR = {2'h0, IRQ_MASK_IDX, 2'h0};
	// control register field positions
	localparam int EN_BIT = 15;
	localparam int AUTO_WAKE_BIT = 14;
	localparam int AUTO_SLEEP_BIT = 13;
	localparam int MAN_BIT = 12;
	localparam int BURST_DIS_BIT = 11;
	localparam int PWR_BIT = 10;
	localparam int ERR_MET_BIT = 9;
	localparam int DATA_MET_BIT = 8;
	localparam int ERR_THR_LSB = 4;
	localparam int DATA_THR_LSB = 0;
	// reset value of the control register, enable bit excluded (strap)
	localparam logic [15:0] CTRL_RESET = 16'h6011;
	// interrupt status and mask layout
	localparam int IRQ_W = 3;
	localparam int IRQ_DATA_BIT = 0;
	localparam int IRQ_ERR_BIT = 1;
	localparam int IRQ_PWR_BIT = 2;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
	// timing
	localparam int unsigned CLK_FREQ_HZ = 40_000_000;
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned IDLE_TIME_MS = 2000;
	localparam int unsigned IDLE_CYCLES = IDLE_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam int IDLE_W = 27;
	localparam int unsigned PULSE_WIDTH_NS = 100;
	localparam int unsigned PULSE_GAP_NS = 1000;
	localparam int unsigned PULSE_WIDTH_CYC = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PULSE_GAP_CYC = (PULSE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] BURST_LEN = 3'h4;
	localparam logic [2:0] SINGLE_LEN = 3'h1;
	// power sequencing states, gray along down, waking, up, sleeping
	typedef enum logic [1:0] {
		PWR_DOWN = 2'h0,
		PWR_WAKING = 2'h1,
		PWR_UP = 2'h3,
		PWR_SLEEPING = 2'h2
	} edpc_pwr_t;
endpackage

// ---- hw/edpc_pulse_gen.sv ----
// sense pulse generator: a burst of four pulses or a single pulse per start
`timescale 1ns/1ps
module edpc_pulse_gen (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic start,
	input wire logic burst_dis,
	output logic pulse,
	output logic done
);
	typedef struct packed {
		logic pulse;
		logic done;
		logic [5:0] cnt;
		logic [2:0] left;
	} edpc_pg_t;
	edpc_pg_t pg_q;
	edpc_pg_t pg_d;

	// pulse high phase, then gap, until the pulse budget is spent
	always_comb begin
		pg_d = pg_q;
		pg_d.done = 1'b0;
		if (start) begin
			pg_d.pulse = 1'b1;
			pg_d.cnt = 6'(edpc_pkg::PULSE_WIDTH_CYC - 1);
			pg_d.left = burst_dis ? edpc_pkg::SINGLE_LEN : edpc_pkg::BURST_LEN;
		end else if (pg_q.left != 3'h0) begin
			if (pg_q.cnt != 6'h0) begin
				pg_d.cnt = pg_q.cnt - 6'h1;
			end else if (pg_q.pulse) begin
				pg_d.pulse = 1'b0;
				pg_d.left = pg_q.left - 3'h1;
				pg_d.cnt = 6'(edpc_pkg::PULSE_GAP_CYC - 1);
				pg_d.done = (pg_q.left == 3'h1); // no trailing gap after the last pulse
			end else begin
				pg_d.pulse = 1'b1;
				pg_d.cnt = 6'(edpc_pkg::PULSE_WIDTH_CYC - 1);
			end
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pg_q <= '0;
		end else if (ce) begin
			pg_q <= pg_d;
		end
	end

	assign pulse = pg_q.pulse;
	assign done = pg_q.done;

	// helper: pulses seen since the last start
	logic [2:0] seen_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_q <= 3'h0;
		end else if (ce) begin
			seen_q <= (start ? 3'h0 : seen_q) + 3'(pg_d.pulse & ~pg_q.pulse);
		end
	end

	sequence pulse_high_s;
		pulse [*4] ##1 !pulse;
	endsequence

	pulse_width_a: assert property (@(posedge pclk) disable iff (!presetn || !ce)
		$rose(pulse) |-> pulse_high_s) else $error("sense pulse width wrong");
	burst_count_a: assert property (@(posedge pclk) disable iff (!presetn || !ce)
		(done && !burst_dis) |-> (seen_q == 3'h4)) else $error("burst did not hold four pulses");
	single_count_a: assert property (@(posedge pclk) disable iff (!presetn || !ce)
		(done && burst_dis) |-> (seen_q == 3'h1)) else $error("single mode sent other than one pulse");
endmodule

// ---- hw/edpc_top.sv ----
// energy-sense power control with apb register slave and interrupt
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module edpc_top #(
	parameter int unsigned IDLE_CYCLES = edpc_pkg::IDLE_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic strap_energy_sense_enable,
	input wire logic energy_present,
	input wire logic data_event,
	input wire logic error_event,
	output logic line_driver_power_up,
	output logic sense_pulse,
	output logic irq
);
	//--------------------------------------------------------------------------
	// state
	//--------------------------------------------------------------------------
	typedef struct packed {
		logic strap_done;
		logic en;
		logic auto_wake;
		logic auto_sleep;
		logic burst_dis;
		logic [3:0] err_thr;
		logic [3:0] data_thr;
		logic err_met;
		logic data_met;
		edpc_pkg::edpc_pwr_t pwr;
		logic [3:0] data_cnt;
		logic [3:0] err_cnt;
		logic [edpc_pkg::IDLE_W-1:0] idle;
		logic start;
		logic [edpc_pkg::IRQ_W-1:0] irq_stat;
		logic [edpc_pkg::IRQ_W-1:0] irq_mask;
		logic ack;
		logic slverr;
		logic [31:0] rdata;
	} edpc_state_t;
	edpc_state_t st_q;
	edpc_state_t st_d;

	logic setup;
	logic wr_fire;
	logic ctrl_hit;
	logic stat_hit;
	logic mask_hit;
	logic pg_done;
	logic [4:0] data_next;
	logic [4:0] err_next;
	logic data_reach;
	logic err_reach;
	logic idle_end;
	logic man_req;
	logic [15:0] ctrl_view;

	//--------------------------------------------------------------------------
	// apb decode and handshake
	//--------------------------------------------------------------------------
	// address decode, one aligned word per register
	always_comb begin
		ctrl_hit = 1'b0;
		stat_hit = 1'b0;
		mask_hit = 1'b0;
		if (paddr == edpc_pkg::CTRL_ADDR) begin
			ctrl_hit = 1'b1;
		end else if (paddr == edpc_pkg::IRQ_STAT_ADDR) begin
			stat_hit = 1'b1;
		end else if (paddr == edpc_pkg::IRQ_MASK_ADDR) begin
			mask_hit = 1'b1;
		end
	end

	// answer in the first access cycle, data prepared in setup
	assign setup = psel & ~penable;
	assign pready = penable & st_q.ack;
	assign pslverr = penable & st_q.ack & st_q.slverr;
	assign prdata = st_q.rdata;
	assign wr_fire = psel & penable & pready & pwrite & ~st_q.slverr;

	//--------------------------------------------------------------------------
	// event counting
	//--------------------------------------------------------------------------
	// saturating-free compare in five bits so threshold fifteen is reachable
	assign data_next = {1'b0, st_q.data_cnt} + 5'h1;
	assign err_next = {1'b0, st_q.err_cnt} + 5'h1;
	assign data_reach = data_event & (data_next >= {1'b0, st_q.data_thr});
	assign err_reach = error_event & (err_next >= {1'b0, st_q.err_thr});
	assign idle_end = (st_q.idle == edpc_pkg::IDLE_W'(IDLE_CYCLES - 1)) & ~data_event;
	assign man_req = wr_fire & ctrl_hit & pstrb[1] & pwdata[edpc_pkg::MAN_BIT];

	// control register as software sees it; the manual toggle reads zero
	assign ctrl_view = {st_q.en, st_q.auto_wake, st_q.auto_sleep, 1'b0, st_q.burst_dis,
		(st_q.pwr == edpc_pkg::PWR_UP), st_q.err_met, st_q.data_met, st_q.err_thr, st_q.data_thr};

	//--------------------------------------------------------------------------
	// next state
	//--------------------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.start = 1'b0;
		// catch the strap on the first enabled cycle after reset release
		if (!st_q.strap_done) begin
			st_d.strap_done = 1'b1;
			st_d.en = strap_energy_sense_enable;
		end
		// idle timer restarts on every data event
		if (data_event || idle_end) begin
			st_d.idle = '0;
		end else begin
			st_d.idle = st_q.idle + edpc_pkg::IDLE_W'(1);
		end
		// event counters, cleared after a long quiet spell
		if (idle_end) begin
			st_d.data_cnt = 4'h0;
			st_d.err_cnt = 4'h0;
		end else begin
			if (data_event && st_q.data_cnt != 4'hF) begin
				st_d.data_cnt = data_next[3:0];
			end
			if (error_event && st_q.err_cnt != 4'hF) begin
				st_d.err_cnt = err_next[3:0];
			end
		end
		// apb read: capture data in setup and clear-on-read flags at the same edge
		if (setup) begin
			st_d.ack = 1'b1;
			st_d.slverr = ~(ctrl_hit | stat_hit | mask_hit);
			st_d.rdata = 32'h0;
			if (!pwrite) begin
				if (ctrl_hit) begin
					st_d.rdata = {16'h0, ctrl_view};
					st_d.rdata[edpc_pkg::ERR_MET_BIT] = st_q.err_met | err_reach;
					st_d.rdata[edpc_pkg::DATA_MET_BIT] = st_q.data_met | data_reach;
					st_d.err_met = 1'b0;
					st_d.data_met = 1'b0;
				end else if (stat_hit) begin
					st_d.rdata = {29'h0, st_q.irq_stat};
				end else if (mask_hit) begin
					st_d.rdata = {29'h0, st_q.irq_mask};
				end
			end
		end else if (pready) begin
			st_d.ack = 1'b0;
			st_d.slverr = 1'b0;
		end
		// apb write, taken at the completing edge
		if (wr_fire && ctrl_hit) begin
			if (pstrb[1]) begin
				st_d.en = pwdata[edpc_pkg::EN_BIT];
				st_d.auto_wake = pwdata[edpc_pkg::AUTO_WAKE_BIT];
				st_d.auto_sleep = pwdata[edpc_pkg::AUTO_SLEEP_BIT];
				st_d.burst_dis = pwdata[edpc_pkg::BURST_DIS_BIT];
			end
			if (pstrb[0]) begin
				st_d.err_thr = pwdata[edpc_pkg::ERR_THR_LSB +: 4];
				st_d.data_thr = pwdata[edpc_pkg::DATA_THR_LSB +: 4];
			end
		end
		if (wr_fire && mask_hit && pstrb[0]) begin
			st_d.irq_mask = pwdata[edpc_pkg::IRQ_W-1:0];
		end
		if (wr_fire && stat_hit && pstrb[0]) begin
			st_d.irq_stat = st_q.irq_stat & ~pwdata[edpc_pkg::IRQ_W-1:0];
		end
		// threshold flags; a new event wins over the read clear
		if (err_reach) begin
			st_d.err_met = 1'b1;
			st_d.irq_stat[edpc_pkg::IRQ_ERR_BIT] = 1'b1;
		end
		if (data_reach) begin
			st_d.data_met = 1'b1;
			st_d.irq_stat[edpc_pkg::IRQ_DATA_BIT] = 1'b1;
		end
		// power sequencing; error events never steer it
		// stay down until the strap is taken, so a reset never flashes the driver on
		if (!st_q.en) begin
			if (st_q.strap_done) begin
				st_d.pwr = edpc_pkg::PWR_UP; // sensing off keeps the driver powered
			end
		end else begin
			case (st_q.pwr)
				edpc_pkg::PWR_DOWN: begin
					if (man_req || (st_q.auto_wake && data_reach)) begin
						st_d.pwr = edpc_pkg::PWR_WAKING;
						st_d.start = 1'b1;
						st_d.data_cnt = 4'h0;
						st_d.err_cnt = 4'h0;
					end
				end
				edpc_pkg::PWR_WAKING: begin
					if (pg_done) begin
						st_d.pwr = edpc_pkg::PWR_UP;
						st_d.irq_stat[edpc_pkg::IRQ_PWR_BIT] = 1'b1;
					end
				end
				edpc_pkg::PWR_UP: begin
					if (man_req || (st_q.auto_sleep && !energy_present)) begin
						st_d.pwr = edpc_pkg::PWR_SLEEPING;
					end
				end
				default: begin
					st_d.pwr = edpc_pkg::PWR_DOWN;
					st_d.irq_stat[edpc_pkg::IRQ_PWR_BIT] = 1'b1;
				end
			endcase
		end
	end

	//--------------------------------------------------------------------------
	// state register
	//--------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
			st_q.auto_wake <= edpc_pkg::CTRL_RESET[edpc_pkg::AUTO_WAKE_BIT];
			st_q.auto_sleep <= edpc_pkg::CTRL_RESET[edpc_pkg::AUTO_SLEEP_BIT];
			st_q.burst_dis <= edpc_pkg::CTRL_RESET[edpc_pkg::BURST_DIS_BIT];
			st_q.err_thr <= edpc_pkg::CTRL_RESET[edpc_pkg::ERR_THR_LSB +: 4];
			st_q.data_thr <= edpc_pkg::CTRL_RESET[edpc_pkg::DATA_THR_LSB +: 4];
			st_q.irq_mask <= edpc_pkg::IRQ_MASK_RESET;
			st_q.pwr <= edpc_pkg::PWR_DOWN;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	//--------------------------------------------------------------------------
	// pulse generator and outputs
	//--------------------------------------------------------------------------
	edpc_pulse_gen u_pulse (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.start(st_q.start),
		.burst_dis(st_q.burst_dis),
		.pulse(sense_pulse),
		.done(pg_done)
	);

	// driver is powered from the start of waking until sleeping completes
	assign line_driver_power_up = (st_q.pwr != edpc_pkg::PWR_DOWN);
	assign irq = |(st_q.irq_stat & st_q.irq_mask);

	//--------------------------------------------------------------------------
	// checks
	//--------------------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn || !ce);

	sequence woke_s;
		st_q.pwr == edpc_pkg::PWR_DOWN ##1 st_q.pwr == edpc_pkg::PWR_WAKING;
	endsequence

	sequence sleep_path_s;
		st_q.pwr == edpc_pkg::PWR_SLEEPING ##1 st_q.pwr == edpc_pkg::PWR_DOWN;
	endsequence

	auto_wake_a: assert property (
		(st_q.en && st_q.strap_done && st_q.pwr == edpc_pkg::PWR_DOWN && st_q.auto_wake && data_reach)
		|=> st_q.pwr == edpc_pkg::PWR_WAKING) else $error("auto wake did not start");
	wake_pulse_a: assert property (
		woke_s |-> ##[1:2] sense_pulse) else $error("no sense pulse after power-up");
	auto_sleep_a: assert property (
		(st_q.en && st_q.strap_done && !(wr_fire && ctrl_hit) && st_q.pwr == edpc_pkg::PWR_UP
		&& st_q.auto_sleep && !energy_present) |=> sleep_path_s) else $error("auto sleep did not complete");
	man_toggle_a: assert property (
		(man_req && st_q.en && st_q.strap_done && st_q.pwr == edpc_pkg::PWR_DOWN)
		|=> st_q.pwr == edpc_pkg::PWR_WAKING && st_q.start) else $error("manual toggle ignored");
	err_no_action_a: assert property (
		(st_q.en && err_reach && !man_req && !data_reach && energy_present && st_q.pwr == edpc_pkg::PWR_DOWN)
		|=> st_q.err_met && st_q.pwr == edpc_pkg::PWR_DOWN) else $error("error event misbehaved");
	read_clear_a: assert property (
		(setup && !pwrite && ctrl_hit && !data_reach) |=> !st_q.data_met) else $error("data flag not cleared");
	idle_reset_a: assert property (
		(idle_end && !(st_q.en && st_q.pwr == edpc_pkg::PWR_DOWN && man_req))
		|=> st_q.data_cnt == 4'h0 && st_q.err_cnt == 4'h0) else $error("counters not cleared after idle");
	pwr_bit_a: assert property (
		(setup && !pwrite && ctrl_hit) |=> st_q.rdata[edpc_pkg::PWR_BIT] == ($past(st_q.pwr) == edpc_pkg::PWR_UP))
		else $error("power state bit wrong");

	// strap reaches the enable bit on the first enabled edge after reset
	strap_load_a: assert property (
		(!st_q.strap_done && !(wr_fire && ctrl_hit)) |=> st_q.en == $past(strap_energy_sense_enable))
		else $error("strap not loaded into enable");
	man_sleep_a: assert property (
		(man_req && st_q.en && st_q.pwr == edpc_pkg::PWR_UP) |=> st_q.pwr == edpc_pkg::PWR_SLEEPING)
		else $error("manual power-down ignored");
	// threshold flags are raised by the event that reaches them
	err_met_set_a: assert property (err_reach |=> st_q.err_met) else $error("error flag not set");
	data_met_set_a: assert property (data_reach |=> st_q.data_met) else $error("data flag not set");
	// the data threshold lands as written and the idle timer never runs past its end
	thr_write_a: assert property (
		(wr_fire && ctrl_hit && pstrb[0]) |=> st_q.data_thr == $past(pwdata[edpc_pkg::DATA_THR_LSB +: 4]))
		else $error("data threshold not written");
	idle_bound_a: assert property (
		st_q.idle <= edpc_pkg::IDLE_W'(IDLE_CYCLES - 1)) else $error("idle timer overran");
endmodule

// ---- bench/edpc_line_model.sv ----
// cable side model: energy level and paced data and error event pulses
`timescale 1ns/1ps
module edpc_line_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic energy_on,
	input wire logic start,
	input wire logic slow,
	input wire logic [3:0] n_data,
	input wire logic [3:0] n_err,
	output logic energy_present,
	output logic data_event,
	output logic error_event,
	output logic busy
);
	logic [3:0] dleft_q;
	logic [3:0] eleft_q;
	logic gap_q;
	logic go;
	// energy follows the bench; busy covers queued and in-flight events
	assign energy_present = energy_on;
	assign busy = start | (dleft_q != 4'h0) | (eleft_q != 4'h0) | data_event | error_event;
	assign go = !gap_q && ((dleft_q | eleft_q) != 4'h0);
	// data events first, then error events, one high cycle each, gapped when slow
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{dleft_q, eleft_q, gap_q, data_event, error_event} <= 11'h0;
		end else if (start) begin
			{dleft_q, eleft_q, gap_q, data_event, error_event} <= {n_data, n_err, 3'h0};
		end else begin
			data_event <= go && dleft_q != 4'h0;
			error_event <= go && dleft_q == 4'h0;
			gap_q <= slow && go;
			if (go && dleft_q != 4'h0) begin
				dleft_q <= dleft_q - 4'h1;
			end else if (go) begin
				eleft_q <= eleft_q - 4'h1;
			end
		end
	end
endmodule

// ---- bench/edpc_tb_top.sv ----
// self-checking bench for the energy-sense power control block
`timescale 1ns/1ps
module edpc_tb_top;
	localparam logic [11:0] CA = edpc_pkg::CTRL_ADDR;
	localparam logic [11:0] SA = edpc_pkg::IRQ_STAT_ADDR;
	localparam logic [11:0] MA = edpc_pkg::IRQ_MASK_ADDR;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic strap = 1'b1;
	logic energy_on = 1'b0;
	logic start = 1'b0;
	logic slow = 1'b0;
	logic [3:0] n_data = 4'h0;
	logic [3:0] n_err = 4'h0;
	logic [31:0] prdata;
	logic pready, pslverr, drv, spulse, irq, energy_present, data_event, error_event, busy;
	logic [31:0] seed = 32'h619E4B61;
	logic [31:0] rd;
	logic err;
	logic [3:0] thr;
	logic pprev = 1'b0;
	int errors = 0;
	int check_count = 0;
	int pcnt = 0;
	int pbase = 0;

	// ----------------------------------------
	// clock, design and line model
	// ----------------------------------------
	always #12.5 pclk = ~pclk;
	edpc_top #(.IDLE_CYCLES(50)) u_edpc_top (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .strap_energy_sense_enable(strap), .energy_present(energy_present),
		.data_event(data_event), .error_event(error_event), .line_driver_power_up(drv),
		.sense_pulse(spulse), .irq(irq));
	edpc_line_model u_edpc_line_model (.pclk(pclk), .presetn(presetn), .energy_on(energy_on), .start(start),
		.slow(slow), .n_data(n_data), .n_err(n_err), .energy_present(energy_present),
		.data_event(data_event), .error_event(error_event), .busy(busy));
	// counts rising edges of the sense pulse output
	always @(posedge pclk) begin
		pprev <= spulse;
		if (spulse === 1'b1 && pprev === 1'b0) begin
			pcnt <= pcnt + 1;
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// control word from flag bits and the two thresholds
	function automatic logic [31:0] cw(input logic [15:0] flags, input logic [3:0] et, input logic [3:0] dt);
		return {16'h0, flags | {8'h00, et, dt}};
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic timeout(input string what);
		errors++;
		$display("CHECK FAILED %s expected done seen timeout", what);
		finish_test();
	endtask
	// one apb transfer; read data and error taken at the ready edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 20) timeout("apb ready");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_drv(input logic v);
		int n;
		for (n = 0; n < 400; n++) begin
			@(negedge pclk);
			if (drv === v) break;
		end
		if (n == 400) timeout("line driver");
	endtask
	// polls the interrupt status until the power state bit is set
	task automatic wait_pwr();
		int n;
		for (n = 0; n < 400; n++) begin
			apb(1'b0, SA, 32'h0);
			if (rd[edpc_pkg::IRQ_PWR_BIT] === 1'b1) break;
		end
		if (n == 400) timeout("power state reached");
	endtask
	task automatic send(input logic [3:0] nd, input logic [3:0] ne);
		int n;
		@(posedge pclk);
		seed = xorshift(seed);
		n_data <= nd;
		n_err <= ne;
		slow <= seed[0];
		start <= 1'b1;
		@(posedge pclk);
		start <= 1'b0;
		for (n = 0; n < 100; n++) begin
			@(negedge pclk);
			if (busy === 1'b0) break;
		end
		if (n == 100) timeout("line events");
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		apb(1'b0, CA, 32'h0);
		chk("ctrl reset", cw(16'hE000, 4'h1, 4'h1), rd);
		apb(1'b0, 12'h080, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		apb(1'b1, MA, 32'h7);
		apb(1'b0, MA, 32'h0);
		chk("irq mask", 32'h7, rd);
		apb(1'b1, CA, 32'h6011);
		apb(1'b0, CA, 32'h0);
		chk("enable rewritten", 32'h6011, rd & 32'hFFFFFBFF);
		// sensing on with negotiation off: crossover sits outside this block and stays off
		apb(1'b1, CA, cw(16'hE000, 4'h0, 4'h3));
		wait_drv(1'b0);
		apb(1'b1, SA, 32'h7);
		// events spaced past the idle time do not add up
		energy_on <= 1'b1;
		send(4'h2, 4'h0);
		repeat (60) @(posedge pclk);
		send(4'h1, 4'h0);
		repeat (10) @(negedge pclk);
		chk("idle clears count", 32'h0, {31'h0, drv});
		repeat (60) @(posedge pclk);
		// random threshold: one event short stays down, the last one wakes
		seed = xorshift(seed);
		thr = {1'b0, seed[2:0]} + 4'h1;
		apb(1'b1, CA, cw(16'hE000, 4'h1, thr));
		send(thr - 4'h1, 4'h0);
		repeat (10) @(negedge pclk);
		chk("below threshold", 32'h0, {31'h0, drv});
		pbase = pcnt;
		send(4'h1, 4'h0);
		wait_drv(1'b1);
		wait_pwr();
		chk("burst pulses", 32'h4, 32'(pcnt - pbase));
		apb(1'b0, CA, 32'h0);
		chk("up with data met", cw(16'hE500, 4'h1, thr), rd);
		apb(1'b0, CA, 32'h0);
		chk("data met cleared", cw(16'hE400, 4'h1, thr), rd);
		chk("irq raised", 32'h1, {31'h0, irq});
		apb(1'b1, SA, 32'h7);
		@(negedge pclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		// no energy: automatic power-down
		energy_on <= 1'b0;
		wait_drv(1'b0);
		wait_pwr();
		apb(1'b0, CA, 32'h0);
		chk("down state", cw(16'hE000, 4'h1, thr), rd);
		// error events only raise a flag; masked interrupt stays low
		apb(1'b1, SA, 32'h7);
		apb(1'b1, MA, 32'h5);
		energy_on <= 1'b1;
		apb(1'b1, CA, cw(16'hE800, 4'h2, 4'hF));
		send(4'h1, 4'h2);
		repeat (10) @(negedge pclk);
		chk("errors keep power", 32'h0, {31'h0, drv});
		chk("error irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, MA, 32'h7);
		@(negedge pclk);
		chk("error irq unmasked", 32'h1, {31'h0, irq});
		apb(1'b0, CA, 32'h0);
		chk("error met", cw(16'hEA00, 4'h2, 4'hF), rd);
		apb(1'b0, CA, 32'h0);
		chk("error met cleared", cw(16'hE800, 4'h2, 4'hF), rd);
		// manual toggle after clearing the interrupt gives a single pulse
		apb(1'b1, SA, 32'h7);
		pbase = pcnt;
		apb(1'b1, CA, cw(16'hF800, 4'h2, 4'hF));
		wait_drv(1'b1);
		wait_pwr();
		chk("single pulse", 32'h1, 32'(pcnt - pbase));
		apb(1'b0, CA, 32'h0);
		chk("toggle self clears", cw(16'hEC00, 4'h2, 4'hF), rd);
		// manual power-down with energy present and auto-sleep off
		apb(1'b1, CA, cw(16'hD800, 4'h2, 4'hF));
		wait_drv(1'b0);
		chk("manual down", 32'h0, {31'h0, drv});
		// reset in mid-run with the strap low: sensing comes back disabled, driver left powered
		@(posedge pclk);
		strap <= 1'b0;
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, CA, 32'h0);
		chk("strap low reset", 32'h6011, rd & 32'hFFFFFBFF);
		repeat (2) @(negedge pclk);
		chk("disabled driver on", 32'h1, {31'h0, drv});
		finish_test();
	end
endmodule
